// >>> design/wocg_clock_ctrl.sv
// wake-only clock gating: per-peripheral wake clocks, core gating, reset-seen flag
`timescale 1ns/1ps

module wocg_clock_ctrl (
  // system clock and main system reset
  input  wire logic                             clk,
  input  wire logic                             resetn,
  // link clock and link-side event from the eSPI block
  input  wire logic                             espi_clk,
  input  wire logic                             espi_irq_evt,
  // pins from the host side
  input  wire wocg_pkg::wocg_pins_t             pins,
  // processor side
  input  wire logic                             sleep_req,
  input  wire logic                             espi_irq_en,
  input  wire logic                             cpu_irq_ack,
  input  wire logic                             sys_seen_clr,
  input  wire logic [wocg_pkg::WAKE_GRP_W-1:0]  wake_only_event_group,
  // outputs
  output logic                                  cpu_irq,
  output wocg_pkg::wocg_clk_en_t                clk_en,
  output logic                                  light_sleep,
  output logic [wocg_pkg::STAT_W-1:0]           power_reset_status
);

  // link domain: event toggle
  logic link_tgl_r;
  logic link_tgl_nxt;

  always_comb begin
    link_tgl_nxt = link_tgl_r ^ espi_irq_evt;
  end

  always_ff @(posedge espi_clk or negedge resetn) begin
    if (!resetn) begin
      link_tgl_r <= 1'b0;
    end else begin
      link_tgl_r <= link_tgl_nxt;
    end
  end

  // system domain: synchronisers
  wocg_pkg::wocg_pins_t pin_s1_r;
  wocg_pkg::wocg_pins_t pin_s2_r;
  wocg_pkg::wocg_pins_t pin_s3_r;
  logic [2:0]           tgl_sync_r;
  logic [2:0]           tgl_sync_nxt;

  always_comb begin
    tgl_sync_nxt = {tgl_sync_r[1:0], link_tgl_r};
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_r   <= wocg_pkg::PINS_IDLE;
      pin_s2_r   <= wocg_pkg::PINS_IDLE;
      pin_s3_r   <= wocg_pkg::PINS_IDLE;
      tgl_sync_r <= 3'h0;
    end else begin
      pin_s1_r   <= pins;
      pin_s2_r   <= pin_s1_r;
      pin_s3_r   <= pin_s2_r;
      tgl_sync_r <= tgl_sync_nxt;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic espi_irq_pls;
  logic espi_wake_ok;
  logic rst_pin_wake;

  assign cs_fall      = pin_s3_r.cs_n & ~pin_s2_r.cs_n;
  assign cs_rise      = ~pin_s3_r.cs_n & pin_s2_r.cs_n;
  assign espi_irq_pls = tgl_sync_r[2] ^ tgl_sync_r[1];
  // eSPI reset level and host standby input gate the select-fall wake term
  assign espi_wake_ok = pin_s2_r.host_standby_reset_input & pin_s2_r.espi_rst_n;
  assign rst_pin_wake = pin_s2_r.espi_rst_pin_wake & ~pin_s3_r.espi_rst_pin_wake;

  // power state machine
  wocg_pkg::wocg_state_t state_r;
  wocg_pkg::wocg_state_t state_nxt;
  logic                  cs_low_r;
  logic                  cs_low_nxt;
  logic [3:0]            tail_r;
  logic [3:0]            tail_nxt;
  logic                  irq_r;
  logic                  irq_nxt;
  logic                  irq_raise;

  always_comb begin
    state_nxt  = state_r;
    cs_low_nxt = cs_low_r;
    tail_nxt   = tail_r;
    irq_raise  = espi_irq_pls & espi_irq_en;
    case (state_r)
      wocg_pkg::ST_RUN: begin
        if (sleep_req && !irq_r) begin
          state_nxt = wocg_pkg::ST_SLEEP;
        end
      end
      wocg_pkg::ST_SLEEP: begin
        if (rst_pin_wake) begin
          state_nxt = wocg_pkg::ST_RUN;
        end else if (cs_fall && espi_wake_ok) begin
          state_nxt  = wocg_pkg::ST_ESPI;
          cs_low_nxt = 1'b1;
          tail_nxt   = wocg_pkg::ESPI_TAIL_CYC;
        end
      end
      wocg_pkg::ST_ESPI: begin
        // a new frame inside the tail re-arms the hold
        if (cs_fall) begin
          cs_low_nxt = 1'b1;
          tail_nxt   = wocg_pkg::ESPI_TAIL_CYC;
        end else if (cs_rise) begin
          cs_low_nxt = 1'b0;
        end
        if (irq_raise) begin
          state_nxt  = wocg_pkg::ST_CPU;
          cs_low_nxt = 1'b0;
        end else if (rst_pin_wake) begin
          state_nxt  = wocg_pkg::ST_RUN;
          cs_low_nxt = 1'b0;
        end else if (!cs_low_r && !cs_fall) begin
          if (tail_r == 4'h0) begin
            state_nxt = wocg_pkg::ST_SLEEP;
          end else begin
            tail_nxt = tail_r - 4'h1;
          end
        end
      end
      wocg_pkg::ST_CPU: begin
        if (sleep_req && !irq_r) begin
          state_nxt = wocg_pkg::ST_SLEEP;
        end
      end
      default: begin
        state_nxt = wocg_pkg::ST_RUN;
      end
    endcase
  end

  // processor interrupt: a new raise outside ST_SLEEP beats an acknowledge; raises in ST_SLEEP are ignored
  always_comb begin
    irq_nxt = irq_r;
    if (cpu_irq_ack) begin
      irq_nxt = 1'b0;
    end
    if (irq_raise && state_r != wocg_pkg::ST_SLEEP) begin
      irq_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r  <= wocg_pkg::ST_RUN;
      cs_low_r <= 1'b0;
      tail_r   <= 4'h0;
      irq_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cs_low_r <= cs_low_nxt;
      tail_r   <= tail_nxt;
      irq_r    <= irq_nxt;
    end
  end

  // clock enables
  wocg_pkg::wocg_clk_en_t en_r;
  wocg_pkg::wocg_clk_en_t en_nxt;
  logic                   awake_nxt;

  assign awake_nxt = (state_nxt == wocg_pkg::ST_RUN) || (state_nxt == wocg_pkg::ST_CPU);

  always_comb begin
    en_nxt.core = awake_nxt;
  end

  genvar gi;
  generate
    for (gi = 0; gi < wocg_pkg::WAKE_GRP_W; gi++) begin : g_periph
      if (gi == wocg_pkg::ESPI_WAKE_BIT) begin : g_espi
        always_comb begin
          en_nxt.periph[gi] = awake_nxt || wake_only_event_group[gi] ||
                              (state_nxt == wocg_pkg::ST_ESPI);
        end
      end else begin : g_other
        always_comb begin
          en_nxt.periph[gi] = awake_nxt || wake_only_event_group[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_r.core   <= wocg_pkg::CORE_EN_RST;
      en_r.periph <= wocg_pkg::PERIPH_EN_RST;
    end else begin
      en_r <= en_nxt;
    end
  end

  // system reset seen flag and light sleep indication
  logic sys_seen_r;
  logic sys_seen_nxt;
  logic sleep_r;
  logic sleep_nxt;

  always_comb begin
    sys_seen_nxt = sys_seen_r & ~sys_seen_clr;
    sleep_nxt    = ~awake_nxt;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sys_seen_r <= wocg_pkg::SYS_SEEN_RST;
      sleep_r    <= 1'b0;
    end else begin
      sys_seen_r <= sys_seen_nxt;
      sleep_r    <= sleep_nxt;
    end
  end

  assign cpu_irq     = irq_r;
  assign clk_en      = en_r;
  assign light_sleep = sleep_r;

  always_comb begin
    power_reset_status = '0;
    power_reset_status[wocg_pkg::SYS_RST_BIT] = sys_seen_r;
  end

endmodule : wocg_clock_ctrl

// >>> design/wocg_pkg.sv
// shared constants and carrier types for the wake-only clock gating block
package wocg_pkg;

  // wake-only event group
  localparam int          WAKE_GRP_W     = 32;
  localparam int          ESPI_WAKE_BIT  = 9;

  // power reset status layout
  localparam int          STAT_W         = 8;
  localparam int          SYS_RST_BIT    = 6;
  localparam logic        SYS_SEEN_RST   = 1'b1;

  // cycles allowed after chip select rises for a late interrupt to cross
  localparam logic [3:0]  ESPI_TAIL_CYC  = 4'h4;

  // reset values of clock enables
  localparam logic        CORE_EN_RST    = 1'b1;
  localparam logic [WAKE_GRP_W-1:0] PERIPH_EN_RST = 32'hFFFF_FFFF;

  // pins sampled from outside the clock domain
  typedef struct packed {
    logic cs_n;
    logic host_standby_reset_input;
    logic espi_rst_n;
    logic espi_rst_pin_wake;
  } wocg_pins_t;

  localparam wocg_pins_t PINS_IDLE = '{cs_n: 1'b1, host_standby_reset_input: 1'b0,
                                       espi_rst_n: 1'b0, espi_rst_pin_wake: 1'b0};

  // clock enables driven to the gates
  typedef struct packed {
    logic                  core;
    logic [WAKE_GRP_W-1:0] periph;
  } wocg_clk_en_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_ESPI,
    ST_CPU
  } wocg_state_t;

endpackage : wocg_pkg

// >>> sim/test_wocg_clock_ctrl.sv
// self-checking bench for the wake-only clock gating block
`timescale 1ns/1ps
module test_wocg_clock_ctrl;
  logic                            clk, resetn, espi_clk, irq_evt, cs_n, stby, erst_n, rpw;
  logic                            sleep_req, irq_en, ack, clr, cpu_irq, light_sleep;
  logic [wocg_pkg::WAKE_GRP_W-1:0] evt;
  logic [wocg_pkg::STAT_W-1:0]     status;
  wocg_pkg::wocg_clk_en_t          clk_en;
  wocg_pkg::wocg_pins_t            pins;
  int                              n_fail, check_count;
  assign pins = '{cs_n: cs_n, host_standby_reset_input: stby, espi_rst_n: erst_n,
                  espi_rst_pin_wake: rpw};
  wocg_host_model i_wocg_host_model (.cs_n(cs_n), .espi_clk(espi_clk), .irq_evt(irq_evt));
  wocg_clock_ctrl i_wocg_clock_ctrl (.clk(clk), .resetn(resetn), .espi_clk(espi_clk),
    .espi_irq_evt(irq_evt), .pins(pins), .sleep_req(sleep_req), .espi_irq_en(irq_en),
    .cpu_irq_ack(ack), .sys_seen_clr(clr), .wake_only_event_group(evt), .cpu_irq(cpu_irq),
    .clk_en(clk_en), .light_sleep(light_sleep), .power_reset_status(status));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // one-cycle strobe on {sleep_req, ack, clr}
  task automatic pulse(input logic [2:0] sel);
    @(posedge clk) {sleep_req, ack, clr} <= sel;
    @(posedge clk) {sleep_req, ack, clr} <= 3'h0;
    tick(2);
  endtask : pulse
  task automatic t_reset;
    @(posedge clk) resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    tick(1);
    chk("status", {24'h00_0000, status}, 32'h0000_0040);
    chk("periph", clk_en.periph, 32'hFFFF_FFFF);
    pulse(3'h1);
    chk("status", {24'h00_0000, status}, 32'h0000_0000);
  endtask : t_reset
  task automatic t_sleep;
    @(posedge clk) evt <= 32'h0000_0008;
    pulse(3'h4);
    chk("core", {31'h0, clk_en.core}, 32'h0000_0000);
    chk("periph", clk_en.periph, 32'h0000_0008);
    @(posedge clk) evt <= '0;
    tick(2);
  endtask : t_sleep
  task automatic t_espi(input logic en, input logic ev, input logic sb);
    @(posedge clk) irq_en <= en;
    stby <= sb;
    tick(4);
    fork
      i_wocg_host_model.frame(60, ev);
      begin
        tick(6);
        chk("wake", {31'h0, clk_en.periph[9]}, {31'h0, sb});
        chk("core", {31'h0, clk_en.core}, 32'h0000_0000);
      end
    join
    tick(14);
    chk("irq", {31'h0, cpu_irq}, {31'h0, en & ev});
    chk("espi", {31'h0, clk_en.periph[9]}, {31'h0, en & ev});
    if (en & ev) begin
      pulse(3'h2);
      chk("core", {31'h0, clk_en.core}, 32'h0000_0001);
      pulse(3'h4);
    end
    chk("sleep", {31'h0, light_sleep}, 32'h0000_0001);
  endtask : t_espi
  task automatic t_rst;
    @(posedge clk) erst_n <= 1'b0;
    tick(8);
    chk("core", {31'h0, clk_en.core}, 32'h0000_0000);
    @(posedge clk) rpw <= 1'b1;
    tick(5);
    chk("core", {31'h0, clk_en.core}, 32'h0000_0001);
    @(posedge clk) rpw <= 1'b0;
    erst_n <= 1'b1;
  endtask : t_rst
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #100us;
    n_fail++;
    report_and_stop();
  end
  initial begin
    {resetn, sleep_req, irq_en, ack, clr, rpw} = '0;
    {stby, erst_n} = 2'h3;
    evt = '0;
    t_reset();
    t_sleep();
    t_espi(1'b0, 1'b0, 1'b1);
    t_espi(1'b0, 1'b1, 1'b1);
    t_espi(1'b1, 1'b1, 1'b1);
    t_espi(1'b0, 1'b0, 1'b0);
    t_rst();
    t_reset();
    report_and_stop();
  end
endmodule : test_wocg_clock_ctrl
bind wocg_clock_ctrl wocg_clock_ctrl_sva i_wocg_clock_ctrl_sva (.clk, .resetn, .pins,
  .espi_irq_en, .cpu_irq_ack, .sys_seen_clr, .wake_only_event_group, .cpu_irq, .clk_en,
  .light_sleep, .power_reset_status);

// >>> sim/wocg_clock_ctrl_sva.sv
// assertion checker for the wake-only clock gating block
`timescale 1ns/1ps
module wocg_clock_ctrl_sva (
  // clock and reset
  input wire logic                            clk,
  input wire logic                            resetn,
  // watched ports of the block
  input wire wocg_pkg::wocg_pins_t            pins,
  input wire logic                            espi_irq_en,
  input wire logic                            cpu_irq_ack,
  input wire logic                            sys_seen_clr,
  input wire logic [wocg_pkg::WAKE_GRP_W-1:0] wake_only_event_group,
  input wire logic                            cpu_irq,
  input wire wocg_pkg::wocg_clk_en_t          clk_en,
  input wire logic                            light_sleep,
  input wire logic [wocg_pkg::STAT_W-1:0]     power_reset_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence cs_fall_s;
    light_sleep && pins.cs_n ##1 !pins.cs_n && pins.host_standby_reset_input && pins.espi_rst_n;
  endsequence
  sequence cs_rise_s;
    light_sleep && !espi_irq_en && !wake_only_event_group[9] && $rose(pins.cs_n);
  endsequence
  core_gated_a: assert property (light_sleep |-> !clk_en.core)
    else $error("core clock on in light sleep");
  periph_follow_a: assert property (light_sleep |->
    clk_en.periph[8:0] == $past(wake_only_event_group[8:0])) else $error("periph enable wrong");
  espi_wake_a: assert property (cs_fall_s |-> ##[2:6] clk_en.periph[9] && !clk_en.core)
    else $error("select fall did not clock bus block alone");
  espi_hold_a: assert property (light_sleep && clk_en.periph[9] && !pins.cs_n
    |=> clk_en.periph[9]) else $error("bus block clock dropped in frame");
  espi_done_a: assert property (cs_rise_s |-> ##[4:14] !clk_en.periph[9])
    else $error("bus block clock left on");
  irq_core_a: assert property (cpu_irq |-> clk_en.core && !light_sleep)
    else $error("interrupt without core clock");
  irq_hold_a: assert property (cpu_irq && !cpu_irq_ack |=> cpu_irq)
    else $error("interrupt dropped without ack");
  rst_nowake_a: assert property (light_sleep && $fell(pins.espi_rst_n) && pins.cs_n
    && !pins.espi_rst_pin_wake |=> (!clk_en.core) [*6]) else $error("bus reset woke core");
  flag_clr_a: assert property (sys_seen_clr |=> !power_reset_status[6])
    else $error("reset flag not cleared");
endmodule : wocg_clock_ctrl_sva

// >>> sim/wocg_host_model.sv
// behavioural host controller that runs bus frames toward the block
`timescale 1ns/1ps
module wocg_host_model (
  // link pins toward the block
  output logic cs_n,
  output logic espi_clk,
  output logic irq_evt
);
  initial begin
    cs_n = 1'b1;
    espi_clk = 1'b0;
    irq_evt = 1'b0;
  end
  // link clock runs only while selected, select held for the whole frame
  task automatic frame(input int n, input logic ev);
    cs_n = 1'b0;
    repeat (n) begin
      #3 espi_clk = 1'b1;
      #3 espi_clk = 1'b0;
    end
    irq_evt = ev;
    #3 espi_clk = 1'b1;
    #3 espi_clk = 1'b0;
    irq_evt = 1'b0;
    cs_n = 1'b1;
  endtask : frame
endmodule : wocg_host_model
